// *** rtl/hfc_pkg.sv ***
// Package with register map, function codes, exception codes and carriers of the command bank
package hfc_pkg;

	// Register word indices of the fast command area
	localparam logic [15:0] HFC_ADDR_RESERVED_WORD_ZERO     = 16'h0000;
	localparam logic [15:0] HFC_ADDR_OPERATION_COMMAND_WORD = 16'h0001;
	localparam logic [15:0] HFC_ADDR_FREQUENCY_REFERENCE    = 16'h0002;
	localparam logic [15:0] HFC_ADDR_OUTPUT_VOLTAGE_GAIN    = 16'h0003;
	localparam logic [15:0] HFC_ADDR_TORQUE_REFERENCE_LIMIT = 16'h0004;

	// Reset values
	localparam logic [15:0] HFC_RST_OPERATION_COMMAND_WORD = 16'h0000;
	localparam logic [15:0] HFC_RST_FREQUENCY_REFERENCE    = 16'h0000;
	localparam logic [15:0] HFC_RST_OUTPUT_VOLTAGE_GAIN    = 16'h03e8;
	localparam logic [15:0] HFC_RST_TORQUE_REFERENCE_LIMIT = 16'h0000;

	// Output voltage gain limits, 0.1 percent per count
	localparam logic [15:0] HFC_GAIN_MIN = 16'h0014;
	localparam logic [15:0] HFC_GAIN_MAX = 16'h07d0;

	// Operation command word fields
	localparam int          HFC_BIT_RUN_A        = 0;
	localparam int          HFC_BIT_RUN_B        = 1;
	localparam int          HFC_BIT_EXT_FAULT    = 2;
	localparam int          HFC_BIT_FAULT_RESET  = 3;
	localparam int          HFC_POS_MF_INPUTS    = 4;
	localparam int          HFC_MF_INPUT_COUNT   = 8;
	localparam logic [15:0] HFC_OPCMD_USED_MASK  = 16'h0fff;

	// Function codes
	localparam logic [7:0] HFC_FC_READ_MULTIPLE  = 8'h03;
	localparam logic [7:0] HFC_FC_WRITE_SINGLE   = 8'h06;
	localparam logic [7:0] HFC_FC_WRITE_MULTIPLE = 8'h10;
	localparam logic [7:0] HFC_FC_READ_WRITE     = 8'h17;

	// Exception codes returned with an answer
	localparam logic [7:0] HFC_EXC_NONE          = 8'h00;
	localparam logic [7:0] HFC_EXC_ILLEGAL_FUNC  = 8'h01;
	localparam logic [7:0] HFC_EXC_ILLEGAL_VALUE = 8'h03;

	// One register word access taken from the protocol engine
	typedef struct packed {
		logic [7:0]  func;
		logic [15:0] addr;
		logic        wr;
		logic [15:0] wdata;
	} hfc_req_t;

	// Answer to one register word access
	typedef struct packed {
		logic [15:0] rdata;
		logic [7:0]  exc;
	} hfc_rsp_t;

	// Run and direction commands towards the drive
	typedef struct packed {
		logic run_fwd;
		logic run_rev;
	} hfc_run_t;

endpackage

// *** rtl/hfc_run_decode.sv ***
// Run command decoder: maps the two run bits onto forward and reverse run commands
`timescale 1ns/10ps

module hfc_run_decode (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Command bits and run method
	input  wire logic             run_a,
	input  wire logic             run_b,
	input  wire logic             run_command_method_select,
	// Decoded run command
	output hfc_pkg::hfc_run_t     run
);
	import hfc_pkg::*;

	hfc_run_t next_run;

	always_comb begin
		if (run_command_method_select) begin
			// Run/stop on bit 0, bit 1 only picks the direction
			next_run.run_fwd = run_a & ~run_b;
			next_run.run_rev = run_a & run_b;
		end else begin
			// Separate forward and reverse run bits; both set means stop
			next_run.run_fwd = run_a & ~run_b;
			next_run.run_rev = run_b & ~run_a;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run <= '0;
		end else begin
			run <= next_run;
		end
	end

endmodule // hfc_run_decode

// *** rtl/hfc_command_bank.sv ***
// Fast command register bank of the drive network option, slave side
`timescale 1ns/10ps

module hfc_command_bank (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                nrst,
	// Word accesses from the protocol engine
	input  wire logic                req_valid,
	input  hfc_pkg::hfc_req_t        req,
	output logic                     req_ready,
	output logic                     rsp_valid,
	output hfc_pkg::hfc_rsp_t        rsp,
	// Forwarding of all other drive registers
	output logic                     ext_req_valid,
	output hfc_pkg::hfc_req_t        ext_req,
	input  wire logic                ext_rsp_valid,
	input  hfc_pkg::hfc_rsp_t        ext_rsp,
	// Drive settings
	input  wire logic                run_command_method_select,
	// Commands refreshed to the drive
	output hfc_pkg::hfc_run_t        run,
	output logic                     option_card_external_fault,
	output logic                     fault_reset,
	output logic [7:0]               mf_inputs,
	output logic [15:0]              frequency_reference,
	output logic [15:0]              output_voltage_gain,
	output logic signed [15:0]       torque_reference_limit
);
	import hfc_pkg::*;

	typedef enum logic [0:0] {
		HFC_IDLE     = 1'b0,
		HFC_WAIT_EXT = 1'b1
	} hfc_state_t;

	// Register file state
	logic [15:0] operation_command_word;
	logic [15:0] next_operation_command_word;
	logic [15:0] next_frequency_reference;
	logic [15:0] next_output_voltage_gain;
	logic [15:0] next_torque_reference_limit;

	// Transaction state
	hfc_state_t  state;
	hfc_state_t  next_state;
	logic        next_req_ready;
	logic        next_rsp_valid;
	hfc_rsp_t    next_rsp;
	logic        next_ext_req_valid;
	hfc_req_t    next_ext_req;

	// Decode helpers
	logic        fc_legal;
	logic        fc_dir_ok;
	logic        is_local;
	logic [15:0] local_rdata;

	// Discrete command outputs
	logic        next_option_card_external_fault;
	logic        next_fault_reset;
	logic [7:0]  next_mf_inputs;

	always_comb begin
		// Function code 17 carries both reads and writes; the others have a fixed direction
		case (req.func)
			HFC_FC_READ_MULTIPLE: begin
				fc_legal  = 1'b1;
				fc_dir_ok = ~req.wr;
			end
			HFC_FC_WRITE_SINGLE, HFC_FC_WRITE_MULTIPLE: begin
				fc_legal  = 1'b1;
				fc_dir_ok = req.wr;
			end
			HFC_FC_READ_WRITE: begin
				fc_legal  = 1'b1;
				fc_dir_ok = 1'b1;
			end
			default: begin
				fc_legal  = 1'b0;
				fc_dir_ok = 1'b0;
			end
		endcase
		is_local = (req.addr <= HFC_ADDR_TORQUE_REFERENCE_LIMIT);
		case (req.addr)
			HFC_ADDR_OPERATION_COMMAND_WORD: local_rdata = operation_command_word;
			HFC_ADDR_FREQUENCY_REFERENCE:    local_rdata = frequency_reference;
			HFC_ADDR_OUTPUT_VOLTAGE_GAIN:    local_rdata = output_voltage_gain;
			HFC_ADDR_TORQUE_REFERENCE_LIMIT: local_rdata = torque_reference_limit;
			default:                         local_rdata = 16'h0000;
		endcase
	end

	always_comb begin
		next_state                  = state;
		next_rsp_valid              = 1'b0;
		next_rsp                    = rsp;
		next_ext_req_valid          = 1'b0;
		next_ext_req                = ext_req;
		next_operation_command_word = operation_command_word;
		next_frequency_reference    = frequency_reference;
		next_output_voltage_gain    = output_voltage_gain;
		next_torque_reference_limit = torque_reference_limit;
		case (state)
			HFC_IDLE: begin
				if (req_valid) begin
					if (!(fc_legal && fc_dir_ok)) begin
						// Every request gets an answer, even a refused one
						next_rsp_valid = 1'b1;
						next_rsp.rdata = 16'h0000;
						next_rsp.exc   = HFC_EXC_ILLEGAL_FUNC;
					end else if (is_local) begin
						next_rsp_valid = 1'b1;
						next_rsp.rdata = req.wr ? 16'h0000 : local_rdata;
						next_rsp.exc   = HFC_EXC_NONE;
						if (req.wr) begin
							case (req.addr)
								HFC_ADDR_OPERATION_COMMAND_WORD: begin
									// Upper nibble is reserved and never stored
									next_operation_command_word = req.wdata & HFC_OPCMD_USED_MASK;
								end
								HFC_ADDR_FREQUENCY_REFERENCE: begin
									next_frequency_reference = req.wdata;
								end
								HFC_ADDR_OUTPUT_VOLTAGE_GAIN: begin
									// Out of range leaves the gain alone so the drive never sees it
									if (req.wdata >= HFC_GAIN_MIN && req.wdata <= HFC_GAIN_MAX) begin
										next_output_voltage_gain = req.wdata;
									end else begin
										next_rsp.exc = HFC_EXC_ILLEGAL_VALUE;
									end
								end
								HFC_ADDR_TORQUE_REFERENCE_LIMIT: begin
									next_torque_reference_limit = req.wdata;
								end
								default: begin
									// Reserved word zero: accepted and dropped
									next_rsp.exc = HFC_EXC_NONE;
								end
							endcase
						end
					end else begin
						// Slow drive registers go out to the drive register port
						next_ext_req_valid = 1'b1;
						next_ext_req       = req;
						next_state         = HFC_WAIT_EXT;
					end
				end
			end
			HFC_WAIT_EXT: begin
				if (ext_rsp_valid) begin
					next_rsp_valid = 1'b1;
					next_rsp       = ext_rsp;
					next_state     = HFC_IDLE;
				end
			end
			default: begin
				next_state = HFC_IDLE;
			end
		endcase
		next_req_ready = (next_state == HFC_IDLE);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state                  <= HFC_IDLE;
			req_ready              <= 1'b1;
			rsp_valid              <= 1'b0;
			rsp                    <= '0;
			ext_req_valid          <= 1'b0;
			ext_req                <= '0;
			operation_command_word <= HFC_RST_OPERATION_COMMAND_WORD;
			frequency_reference    <= HFC_RST_FREQUENCY_REFERENCE;
			output_voltage_gain    <= HFC_RST_OUTPUT_VOLTAGE_GAIN;
			torque_reference_limit <= HFC_RST_TORQUE_REFERENCE_LIMIT;
		end else begin
			state                  <= next_state;
			req_ready              <= next_req_ready;
			rsp_valid              <= next_rsp_valid;
			rsp                    <= next_rsp;
			ext_req_valid          <= next_ext_req_valid;
			ext_req                <= next_ext_req;
			operation_command_word <= next_operation_command_word;
			frequency_reference    <= next_frequency_reference;
			output_voltage_gain    <= next_output_voltage_gain;
			torque_reference_limit <= next_torque_reference_limit;
		end
	end

	// Discrete command bits are registered again so each output comes from its own flop
	always_comb begin
		next_option_card_external_fault = operation_command_word[HFC_BIT_EXT_FAULT];
		next_fault_reset                = operation_command_word[HFC_BIT_FAULT_RESET];
		next_mf_inputs                  = operation_command_word[HFC_POS_MF_INPUTS +: HFC_MF_INPUT_COUNT];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			option_card_external_fault <= 1'b0;
			fault_reset                <= 1'b0;
			mf_inputs                  <= 8'h00;
		end else begin
			option_card_external_fault <= next_option_card_external_fault;
			fault_reset                <= next_fault_reset;
			mf_inputs                  <= next_mf_inputs;
		end
	end

	// The input field must fill the port and stay clear of the reserved top nibble
	if (HFC_MF_INPUT_COUNT != 8 || HFC_POS_MF_INPUTS + HFC_MF_INPUT_COUNT > 12) begin : g_mf_field_check
		$error("multi-function input field does not fit the command word");
	end

	hfc_run_decode i_hfc_run_decode (
		.clk                       (clk),
		.nrst                      (nrst),
		.run_a                     (operation_command_word[HFC_BIT_RUN_A]),
		.run_b                     (operation_command_word[HFC_BIT_RUN_B]),
		.run_command_method_select (run_command_method_select),
		.run                       (run)
	);

endmodule // hfc_command_bank

// *** testbench/hfc_command_bank_sva.sv ***
// Port assertions for the fast command register bank
`timescale 1ns/10ps
module hfc_command_bank_sva (
	// Clock and reset
	input wire logic               clk,
	input wire logic               nrst,
	// Request port
	input wire logic               req_valid,
	input hfc_pkg::hfc_req_t       req,
	input wire logic               req_ready,
	input wire logic               rsp_valid,
	input hfc_pkg::hfc_rsp_t       rsp,
	// Forwarding port
	input wire logic               ext_req_valid,
	input hfc_pkg::hfc_req_t       ext_req,
	input wire logic               ext_rsp_valid,
	input hfc_pkg::hfc_rsp_t       ext_rsp,
	// Drive side
	input wire logic               run_command_method_select,
	input hfc_pkg::hfc_run_t       run,
	input wire logic               option_card_external_fault,
	input wire logic               fault_reset,
	input wire logic [7:0]         mf_inputs,
	input wire logic [15:0]        frequency_reference,
	input wire logic [15:0]        output_voltage_gain,
	input wire logic signed [15:0] torque_reference_limit
);
	import hfc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic acc, wr_ok;
	assign acc = req_valid && req_ready;
	assign wr_ok = acc && req.wr && (req.func == 8'h06 || req.func == 8'h10 || req.func == 8'h17);
	a_local_answer: assert property (acc && req.addr <= 16'h4 |=> rsp_valid) else $error("no answer");
	a_bad_func: assert property (acc && !(req.func inside {8'h03, 8'h06, 8'h10, 8'h17})
		|=> rsp_valid && rsp.exc == 8'h01) else $error("bad function not refused");
	a_fwd_req: assert property (acc && req.addr > 16'h4 && req.func == 8'h03 && !req.wr
		|=> ext_req_valid && ext_req == $past(req)) else $error("not forwarded");
	a_fwd_rsp: assert property (ext_rsp_valid && !req_ready |=> rsp_valid && rsp == $past(ext_rsp))
		else $error("forwarded answer lost");
	a_fwd_stall: assert property (ext_req_valid |-> !req_ready) else $error("ready while forwarding");
	a_gain_range: assert property (output_voltage_gain >= 16'h14 && output_voltage_gain <= 16'h7d0)
		else $error("gain out of range");
	a_gain_bad: assert property (wr_ok && req.addr == 16'h3 && (req.wdata < 16'h14 || req.wdata > 16'h7d0)
		|=> rsp.exc == 8'h03 && $stable(output_voltage_gain)) else $error("bad gain taken");
	a_rsvd_zero: assert property (acc && !req.wr && req.func == 8'h03 && req.addr <= 16'h1
		|=> rsp.rdata[15:12] == 4'h0 && (rsp.rdata == 16'h0 || $past(req.addr) != 16'h0))
		else $error("reserved bits not zero");
	a_op_out: assert property (wr_ok && req.addr == 16'h1 |=> ##1 mf_inputs == $past(req.wdata[11:4], 2)
		&& fault_reset == $past(req.wdata[3], 2) && option_card_external_fault == $past(req.wdata[2], 2))
		else $error("op word outputs wrong");
	a_freq_wr: assert property (wr_ok && req.addr == 16'h2 |=> frequency_reference == $past(req.wdata))
		else $error("frequency not stored");
	a_torque_wr: assert property (wr_ok && req.addr == 16'h4 |=> torque_reference_limit == $past(req.wdata))
		else $error("torque not stored");
	c_fwd: cover property (ext_req_valid);
	c_gain_bad: cover property (rsp_valid && rsp.exc == 8'h03);
	c_rev: cover property (run.run_rev);
endmodule // hfc_command_bank_sva

bind hfc_command_bank hfc_command_bank_sva i_hfc_command_bank_sva (
	.clk                        (clk),
	.nrst                       (nrst),
	.req_valid                  (req_valid),
	.req                        (req),
	.req_ready                  (req_ready),
	.rsp_valid                  (rsp_valid),
	.rsp                        (rsp),
	.ext_req_valid              (ext_req_valid),
	.ext_req                    (ext_req),
	.ext_rsp_valid              (ext_rsp_valid),
	.ext_rsp                    (ext_rsp),
	.run_command_method_select  (run_command_method_select),
	.run                        (run),
	.option_card_external_fault (option_card_external_fault),
	.fault_reset                (fault_reset),
	.mf_inputs                  (mf_inputs),
	.frequency_reference        (frequency_reference),
	.output_voltage_gain        (output_voltage_gain),
	.torque_reference_limit     (torque_reference_limit)
);

// *** testbench/hfc_drive_port_model.sv ***
// Drive register port model answering forwarded word accesses
`timescale 1ns/10ps
module hfc_drive_port_model #(
	parameter int DLY = 3
) (
	// Clock
	input wire logic         clk,
	// Forwarded request and answer
	input wire logic         ext_req_valid,
	input hfc_pkg::hfc_req_t ext_req,
	output logic             ext_rsp_valid,
	output hfc_pkg::hfc_rsp_t ext_rsp
);
	import hfc_pkg::*;
	logic [15:0] a;
	initial begin
		ext_rsp_valid = 1'b0;
		ext_rsp = '1;
	end
	// Slow answer; idle data is inverted so a stale value never matches
	always begin
		@(posedge clk);
		#1;
		if (ext_req_valid === 1'b1) begin
			a = ext_req.addr;
			repeat (DLY) @(posedge clk);
			#1;
			ext_rsp_valid = 1'b1;
			ext_rsp = '{a ^ 16'h5a5a, 8'h00};
			@(posedge clk);
			#1;
			ext_rsp_valid = 1'b0;
			ext_rsp = ~ext_rsp;
		end
	end
endmodule // hfc_drive_port_model

// *** testbench/tb_hfc_command_bank.sv ***
// Testbench for the fast command register bank
`timescale 1ns/10ps
module tb_hfc_command_bank;
	import hfc_pkg::*;
	logic clk = 0, nrst = 0, req_valid = 0, run_command_method_select = 0, req_ready, rsp_valid;
	logic ext_req_valid, ext_rsp_valid, option_card_external_fault, fault_reset;
	logic [7:0] mf_inputs;
	logic [15:0] frequency_reference, output_voltage_gain;
	logic signed [15:0] torque_reference_limit;
	hfc_req_t req = '0, ext_req;
	hfc_rsp_t rsp, ext_rsp, r;
	hfc_run_t run;
	int fails = 0, samples_checked = 0, cyc = 0;
	always #50 clk = ~clk;
	hfc_command_bank i_hfc_command_bank (
		.clk                        (clk),
		.nrst                       (nrst),
		.req_valid                  (req_valid),
		.req                        (req),
		.req_ready                  (req_ready),
		.rsp_valid                  (rsp_valid),
		.rsp                        (rsp),
		.ext_req_valid              (ext_req_valid),
		.ext_req                    (ext_req),
		.ext_rsp_valid              (ext_rsp_valid),
		.ext_rsp                    (ext_rsp),
		.run_command_method_select  (run_command_method_select),
		.run                        (run),
		.option_card_external_fault (option_card_external_fault),
		.fault_reset                (fault_reset),
		.mf_inputs                  (mf_inputs),
		.frequency_reference        (frequency_reference),
		.output_voltage_gain        (output_voltage_gain),
		.torque_reference_limit     (torque_reference_limit)
	);
	hfc_drive_port_model i_hfc_drive_port_model (
		.clk           (clk),
		.ext_req_valid (ext_req_valid),
		.ext_req       (ext_req),
		.ext_rsp_valid (ext_rsp_valid),
		.ext_rsp       (ext_rsp)
	);
	task tally_and_finish;
		$display("checked %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish;
		end
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One word access; a spare cycle follows so req_valid is never set twice in a step
	task acc(input logic [7:0] f, input logic [15:0] a, input logic w, input logic [15:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		req_valid = 1'b1;
		req = '{f, a, w, d};
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (rsp_valid !== 1'b1) begin
			fails++;
			$display("[ERR] %0t no answer, rsp_valid %h exp %h", $time, rsp_valid, 1'b1);
		end
		r = rsp;
		@(posedge clk);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk(output_voltage_gain, 16'h03e8);
		chk(frequency_reference, 16'h0);
		$display("reset test done");
		acc(8'h06, 16'h2, 1, 16'h1234);
		acc(8'h03, 16'h2, 0, 16'h0);
		chk(r.rdata, 16'h1234);
		acc(8'h10, 16'h4, 1, 16'hff38);
		chk(torque_reference_limit, 16'hff38);
		acc(8'h17, 16'h4, 0, 16'h0);
		chk(r.rdata, 16'hff38);
		$display("data test done");
		acc(8'h06, 16'h3, 1, 16'h0013);
		chk(r.exc, 16'h03);
		acc(8'h06, 16'h3, 1, 16'h07d1);
		chk(r.exc, 16'h03);
		acc(8'h06, 16'h3, 1, 16'h0014);
		chk(output_voltage_gain, 16'h0014);
		acc(8'h10, 16'h3, 1, 16'h07d0);
		chk(output_voltage_gain, 16'h07d0);
		$display("gain test done");
		// Reset in mid-run must bring the gain and torque limit words back to their power-up values
		nrst = 1'b0;
		@(posedge clk);
		#1;
		nrst = 1'b1;
		chk(output_voltage_gain, 16'h03e8);
		chk(torque_reference_limit, 16'h0);
		$display("second reset test done");
		acc(8'h04, 16'h2, 0, 16'h0);
		chk(r.exc, 16'h01);
		acc(8'h03, 16'h2, 1, 16'h0);
		chk(r.exc, 16'h01);
		// The next write to word zero breaks the master's duty on purpose; the read after it shows it is harmless
		acc(8'h06, 16'h0, 1, 16'h0);
		chk(r.exc, 16'h00);
		acc(8'h03, 16'h0, 0, 16'h0);
		chk(r.rdata, 16'h0);
		acc(8'h06, 16'h1, 1, 16'hffff);
		chk(mf_inputs, 16'hff);
		chk({option_card_external_fault, fault_reset}, 16'h3);
		acc(8'h03, 16'h1, 0, 16'h0);
		chk(r.rdata, 16'h0fff);
		$display("command word test done");
		for (int m = 0; m < 2; m++)
			for (int b = 0; b < 4; b++) begin
				run_command_method_select = m[0];
				acc(8'h06, 16'h1, 1, 16'(b));
				chk(run.run_fwd, b[0] & ~b[1]);
				chk(run.run_rev, m ? b[0] & b[1] : b[1] & ~b[0]);
			end
		$display("run test done");
		acc(8'h03, 16'h2000, 0, 16'h0);
		chk(r.rdata, 16'h2000 ^ 16'h5a5a);
		chk(r.exc, 16'h00);
		$display("forward test done");
		tally_and_finish;
	end
endmodule // tb_hfc_command_bank
